// >>> hw/lbhrc_pkg.sv
/*
 * Constants and phase type for the local bus hold/ready control block.
 * Assumes a single 10 MHz local bus clock and an active-low async reset.
 */
package lbhrc_pkg;
	localparam int unsigned ADDR_W = 4;
	localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] REG_STAT = 4'h4;
	// control register bit positions
	localparam int unsigned CTRL_CFG_DIS = 0;
	localparam int unsigned CTRL_CORE_RST = 1;
	localparam int unsigned CTRL_EXT_MC = 2;
	// status register bit positions
	localparam int unsigned STAT_GRANT = 0;
	localparam int unsigned STAT_WRITE = 1;
	localparam int unsigned STAT_DEFER = 2;
	localparam int unsigned STAT_HOLDRST = 3;
	localparam int unsigned STAT_PHASE = 4;
	localparam int unsigned PHASE_W = 3;
	localparam logic [1:0] SIZE_8 = 2'h0;
	localparam logic [1:0] SIZE_16 = 2'h1;
	localparam logic [1:0] SIZE_32 = 2'h2;
	localparam logic [7:0] CTRL_RESET = 8'h00;
	typedef enum logic [PHASE_W-1:0] {
		idle_phase,
		addr_phase,
		xfer_phase,
		wait_phase,
		recovery_phase,
		bus_surrender_phase
	} lbhrc_phase_t;
endpackage

// >>> hw/lbhrc_sync.sv
/*
 * Two-flop synchroniser, WIDTH bits wide.
 * Assumes inputs come from pins outside the clock domain.
 */
module lbhrc_sync #(
	parameter int unsigned WIDTH = 1
) (
	input  wire logic             ref_clk,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] stage1;
	logic [WIDTH-1:0] next_stage1;
	logic [WIDTH-1:0] next_q;

	always_comb
	begin
		next_stage1 = clk_en ? d : stage1;
		next_q = clk_en ? stage1 : q;
	end

	// output reads zero until two enabled edges after release
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			stage1 <= '0;
			q <= '0;
		end
		else
		begin
			stage1 <= next_stage1;
			q <= next_q;
		end
	end
endmodule

// >>> hw/lbhrc_top.sv
/*
 * Local bus cycle control: bus hand-over to an outside master, wait and
 * recovery insertion, write/read and size pins, reset straps and the
 * configuration-retry gate for the primary PCI side.
 * Assumes the core issues one access request at a time on acc_req and
 * that only the hold strap, bus request, ready/recover and defer pins arrive asynchronously to ref_clk.
 */
module lbhrc_top (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	input  wire logic       bus_req_in,
	input  wire logic       ext_ready_recover_n,
	input  wire logic       int_ready_n,
	input  wire logic       lock_active,
	input  wire logic       core_halted,
	input  wire logic       cfg_defer_pin,
	input  wire logic       core_hold_strap_n,
	input  wire logic       acc_req,
	input  wire logic       acc_write,
	input  wire logic [1:0] acc_size,
	input  wire logic       acc_last,
	input  wire logic       cfg_cycle,
	input  wire logic [3:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	output logic            bus_grant_out,
	output logic            bus_drive_en,
	output logic            write_read_out,
	output logic            bus_size_code_hi,
	output logic            bus_size_code_lo,
	output logic            size_oe,
	output logic            acc_done,
	output logic            cfg_retry,
	output logic            core_reset
);
	lbhrc_pkg::lbhrc_phase_t phase;
	lbhrc_pkg::lbhrc_phase_t next_phase;
	logic [3:0] pins_s;
	logic       req_s;
	logic       rdy_s;
	logic       defer_s;
	logic       hold_n_s;
	logic [1:0] settle;
	logic [1:0] next_settle;
	logic       straps_taken;
	logic       next_straps_taken;
	logic       defer_strap;
	logic       next_defer_strap;
	logic       hold_strap;
	logic       next_hold_strap;
	logic [7:0] ctrl;
	logic [7:0] next_ctrl;
	logic       wr_latch;
	logic       next_wr_latch;
	logic [1:0] size_latch;
	logic [1:0] next_size_latch;
	logic       ready_ok;
	logic [7:0] next_rdata;
	logic       next_grant;
	logic       next_drive;
	logic       next_done;
	logic       next_retry;
	logic       next_core_reset;

	function automatic logic hit(input logic [3:0] a, input logic [3:0] r);
		hit = (a == r);
	endfunction

	lbhrc_sync #(
		.WIDTH (4)
	) u_sync (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.clk_en  (clk_en),
		.d       ({core_hold_strap_n, bus_req_in, ext_ready_recover_n,
			cfg_defer_pin}),
		.q       (pins_s)
	);
	assign hold_n_s = pins_s[3];
	assign req_s = pins_s[2];
	assign rdy_s = pins_s[1];
	assign defer_s = pins_s[0];

	assign ready_ok = ctrl[lbhrc_pkg::CTRL_EXT_MC] ? !rdy_s : !int_ready_n;

	always_comb
	begin
		next_phase = phase;
		next_wr_latch = wr_latch;
		next_size_latch = size_latch;
		next_done = 1'b0;
		unique case (phase)
			lbhrc_pkg::idle_phase:
			begin
				if (req_s && !lock_active)
					next_phase = lbhrc_pkg::bus_surrender_phase;
				else if (acc_req && !core_halted)
				begin
					next_phase = lbhrc_pkg::addr_phase;
					next_wr_latch = acc_write;
					next_size_latch = acc_size;
				end
			end
			lbhrc_pkg::addr_phase:
				next_phase = lbhrc_pkg::xfer_phase;
			lbhrc_pkg::xfer_phase, lbhrc_pkg::wait_phase:
			begin
				if (!ready_ok)
					next_phase = lbhrc_pkg::wait_phase;
				else if (acc_last)
				begin
					next_phase = lbhrc_pkg::recovery_phase;
					next_done = 1'b1;
				end
				else
					next_phase = lbhrc_pkg::xfer_phase;
			end
			lbhrc_pkg::recovery_phase:
			begin
				if (!ctrl[lbhrc_pkg::CTRL_EXT_MC] || rdy_s)
					next_phase = lbhrc_pkg::idle_phase;
			end
			lbhrc_pkg::bus_surrender_phase:
			begin
				if (!req_s)
				begin
					if (acc_req && !core_halted)
					begin
						next_phase = lbhrc_pkg::addr_phase;
						next_wr_latch = acc_write;
						next_size_latch = acc_size;
					end
					else
						next_phase = lbhrc_pkg::idle_phase;
				end
			end
		endcase
		next_grant = (next_phase == lbhrc_pkg::bus_surrender_phase);
		next_drive = !next_grant;
		if (!clk_en)
		begin
			next_phase = phase;
			next_wr_latch = wr_latch;
			next_size_latch = size_latch;
			next_done = acc_done;
			next_grant = bus_grant_out;
			next_drive = bus_drive_en;
		end
	end

	always_comb
	begin
		next_settle = settle;
		next_straps_taken = straps_taken;
		next_defer_strap = defer_strap;
		next_hold_strap = hold_strap;
		next_ctrl = ctrl;
		next_rdata = reg_rdata;
		if (clk_en)
		begin
			next_settle = {settle[0], 1'b1};
			// straps caught once sync stages hold the pins
			// sync flops still read reset zeros on the first edges
			if (!straps_taken)
			begin
				if (settle[1])
				begin
					next_straps_taken = 1'b1;
					next_hold_strap = !hold_n_s;
					next_defer_strap = defer_s && hold_n_s;
					next_ctrl[lbhrc_pkg::CTRL_CFG_DIS] = defer_s && hold_n_s;
					next_ctrl[lbhrc_pkg::CTRL_CORE_RST] = !hold_n_s;
				end
			end
			else if (reg_wr && hit(reg_addr, lbhrc_pkg::REG_CTRL))
				next_ctrl = reg_wdata;
			next_rdata = 8'h00;
			if (reg_rd && hit(reg_addr, lbhrc_pkg::REG_CTRL))
				next_rdata = ctrl;
			else if (reg_rd && hit(reg_addr, lbhrc_pkg::REG_STAT))
			begin
				next_rdata[lbhrc_pkg::STAT_GRANT] = bus_grant_out;
				next_rdata[lbhrc_pkg::STAT_WRITE] = wr_latch;
				next_rdata[lbhrc_pkg::STAT_DEFER] = defer_strap;
				next_rdata[lbhrc_pkg::STAT_HOLDRST] = hold_strap;
				next_rdata[lbhrc_pkg::STAT_PHASE +: lbhrc_pkg::PHASE_W] =
					phase;
			end
		end
		next_retry = straps_taken ? next_ctrl[lbhrc_pkg::CTRL_CFG_DIS]
			&& cfg_cycle : cfg_retry;
		next_core_reset = !straps_taken ||
			next_ctrl[lbhrc_pkg::CTRL_CORE_RST];
	end

	// register stage; outputs all flopped
	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			phase <= lbhrc_pkg::idle_phase;
			settle <= 2'h0;
			wr_latch <= 1'b0;
			size_latch <= lbhrc_pkg::SIZE_32;
			acc_done <= 1'b0;
			bus_grant_out <= 1'b0;
			bus_drive_en <= 1'b1;
			straps_taken <= 1'b0;
			defer_strap <= 1'b0;
			hold_strap <= 1'b0;
			ctrl <= lbhrc_pkg::CTRL_RESET;
			reg_rdata <= 8'h00;
			cfg_retry <= 1'b0;
			core_reset <= 1'b1;
			write_read_out <= 1'b0;
			bus_size_code_hi <= 1'b0;
			bus_size_code_lo <= 1'b0;
			size_oe <= 1'b0;
		end
		else
		begin
			phase <= next_phase;
			settle <= next_settle;
			wr_latch <= next_wr_latch;
			size_latch <= next_size_latch;
			acc_done <= next_done;
			bus_grant_out <= next_grant;
			bus_drive_en <= next_drive;
			straps_taken <= next_straps_taken;
			defer_strap <= next_defer_strap;
			hold_strap <= next_hold_strap;
			ctrl <= next_ctrl;
			reg_rdata <= next_rdata;
			cfg_retry <= next_retry;
			core_reset <= next_core_reset;
			write_read_out <= next_wr_latch;
			bus_size_code_hi <= next_size_latch[1];
			bus_size_code_lo <= next_size_latch[0];
			size_oe <= next_drive && next_straps_taken;
		end
	end
endmodule

// >>> verification/lbhrc_checker.sv
/* pin-level assertions for lbhrc_top
   bound into every lbhrc_top instance, one clock domain */
module lbhrc_checker (
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic bus_req_in,
	input wire logic lock_active,
	input wire logic bus_grant_out,
	input wire logic bus_drive_en,
	input wire logic size_oe,
	input wire logic bus_size_code_hi,
	input wire logic bus_size_code_lo,
	input wire logic write_read_out,
	input wire logic acc_done
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	sequence s_drop;
		$fell(bus_req_in);
	endsequence
	sequence s_back;
		!bus_grant_out && bus_drive_en;
	endsequence
	property p_drive;
		bus_grant_out != bus_drive_en;
	endproperty
	property p_req;
		bus_grant_out |-> $past(bus_req_in, 3);
	endproperty
	property p_back;
		s_drop |-> ##[1:4] s_back;
	endproperty
	property p_lock;
		$rose(bus_grant_out) |-> !$past(lock_active);
	endproperty
	property p_oe;
		bus_grant_out |-> !size_oe;
	endproperty
	property p_size;
		size_oe |-> !(bus_size_code_hi && bus_size_code_lo);
	endproperty
	property p_pulse;
		acc_done |=> !acc_done;
	endproperty
	property p_wr;
		acc_done |-> $stable(write_read_out) && $stable(bus_size_code_lo);
	endproperty
	a_drive: assert property (p_drive) else $error("drive not inverse");
	a_req: assert property (p_req) else $error("grant without request");
	a_back: assert property (p_back) else $error("bus not taken back");
	a_lock: assert property (p_lock) else $error("grant under lock");
	a_oe: assert property (p_oe) else $error("size driven in grant");
	a_size: assert property (p_size) else $error("size code 11");
	a_pulse: assert property (p_pulse) else $error("done too long");
	a_wr: assert property (p_wr) else $error("write/read moved");
endmodule

bind lbhrc_top lbhrc_checker u_chk (.ref_clk, .rst_n, .bus_req_in,
	.lock_active, .bus_grant_out, .bus_drive_en, .size_oe,
	.bus_size_code_hi, .bus_size_code_lo, .write_read_out, .acc_done);

// >>> verification/lbhrc_mem_model.sv
/* outside memory controller driving the ready/recover pin
   assumes start is a one-cycle pulse as an access is requested */
module lbhrc_mem_model (
	input  wire logic       ref_clk,
	input  wire logic       start,
	input  wire logic [2:0] waits,
	input  wire logic       acc_done,
	output logic            ext_ready_recover_n
);
	timeunit 1ns;
	timeprecision 1ns;
	int st = 0;
	int cnt = 0;
	always @(posedge ref_clk)
	begin
		if (start)
		begin
			st <= 1;
			cnt <= int'(waits);
		end
		else if (st == 1 && cnt > 0)
			cnt <= cnt - 1;
		else if (st == 1)
			st <= 2;
		else if (st == 2 && acc_done)
		begin
			st <= 3;
			cnt <= 3;
		end
		else if (st == 3 && cnt > 0)
			cnt <= cnt - 1;
		else if (st == 3)
			st <= 0;
	end
	// low while data may move and through the recovery count after acc_done
	assign ext_ready_recover_n = !(st == 2 || st == 3);
endmodule

// >>> verification/testbench.sv
/* self-checking bench for lbhrc_top with an outside memory model
   assumes the design files and the memory model are compiled first */
module testbench;
	timeunit 1ns;
	timeprecision 1ns;
	logic ref_clk = 0, rst_n = 0, bus_req_in = 0, lock_active = 0;
	logic core_halted = 0, cfg_defer_pin = 0, core_hold_strap_n = 1;
	logic acc_req = 0, acc_write = 0, reg_wr = 0, reg_rd = 0, start = 0;
	logic [1:0] acc_size = 0;
	logic [2:0] waits = 0;
	logic [3:0] reg_addr = 0;
	logic [7:0] reg_wdata = 0, reg_rdata;
	logic bus_grant_out, bus_drive_en, write_read_out, bus_size_code_hi;
	logic bus_size_code_lo, acc_done, cfg_retry, core_reset, size_oe;
	logic ext_ready_recover_n;
	logic [2:0] q[$];
	int n_mismatch = 0, samples_checked = 0;
	lbhrc_top dut (.ref_clk, .rst_n, .clk_en(1'b1), .bus_req_in,
		.ext_ready_recover_n, .int_ready_n(1'b0), .lock_active,
		.core_halted, .cfg_defer_pin, .core_hold_strap_n, .acc_req,
		.acc_write, .acc_size, .acc_last(1'b1), .cfg_cycle(1'b1),
		.reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.bus_grant_out, .bus_drive_en, .write_read_out,
		.bus_size_code_hi, .bus_size_code_lo, .size_oe, .acc_done,
		.cfg_retry, .core_reset);
	lbhrc_mem_model u_mem (.ref_clk, .start, .waits, .acc_done,
		.ext_ready_recover_n);
	initial forever #50 ref_clk = ~ref_clk;
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		samples_checked++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic results();
		$display("checked %0d bad %0d", samples_checked, n_mismatch);
		if (n_mismatch == 0 && samples_checked > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask
	task automatic do_reset(input logic d, input logic h);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		cfg_defer_pin <= d;
		core_hold_strap_n <= h;
		cyc(6);
		rst_n <= 1'b1;
		cyc(6);
		#1 chk(cfg_retry, d & h);
		chk(core_reset, !h);
		rd(lbhrc_pkg::REG_STAT, {4'h0, !h, d & h, 2'h0});
		wr(lbhrc_pkg::REG_CTRL, 8'h04);
		cyc(2);
		#1 chk({cfg_retry, core_reset}, 8'h00);
		rd(lbhrc_pkg::REG_CTRL, 8'h04);
		rd(4'h8, 8'h00);
	endtask
	task automatic access(input logic ext);
		int w, t;
		logic [1:0] sz;
		logic wrt;
		logic [2:0] e;
		w = $urandom % 4;
		sz = 2'($urandom % 3);
		wrt = 1'($urandom);
		wr(lbhrc_pkg::REG_CTRL, {5'h0, ext, 2'h0});
		@(posedge ref_clk);
		acc_req <= 1'b1;
		acc_write <= wrt;
		acc_size <= sz;
		start <= ext;
		waits <= 3'(w);
		q.push_back({wrt, sz});
		t = 0;
		do
		begin
			@(posedge ref_clk);
			start <= 1'b0;
			#1 t++;
		end
		while (acc_done !== 1'b1 && t < 60);
		e = q.pop_front();
		chk(acc_done, 8'h01);
		chk(write_read_out, e[2]);
		chk({bus_size_code_hi, bus_size_code_lo}, e[1:0]);
		chk(size_oe, 8'h01);
		chk(8'(t > w + 2 || !ext), 8'h01);
		@(posedge ref_clk);
		acc_req <= 1'b0;
		rd(lbhrc_pkg::REG_STAT, {1'b0, ext, 4'h0, wrt, 1'b0});
		cyc(10);
	endtask
	task automatic hold(input logic halted);
		@(posedge ref_clk);
		lock_active <= 1'b1;
		core_halted <= halted;
		bus_req_in <= 1'b1;
		cyc(8);
		#1 chk(bus_grant_out, 8'h00);
		@(posedge ref_clk);
		lock_active <= 1'b0;
		cyc(4);
		#1 chk({bus_grant_out, bus_drive_en}, 8'h02);
		@(posedge ref_clk);
		bus_req_in <= 1'b0;
		cyc(4);
		#1 chk({bus_grant_out, bus_drive_en}, 8'h01);
	endtask
	initial
	begin
		#500000;
		n_mismatch++;
		results();
	end
	initial
	begin
		void'($urandom(75));
		for (int i = 0; i < 3; i++)
			do_reset(i < 2, i != 1);
		$display("strap test done");
		for (int i = 0; i < 12; i++)
			access(1'(i % 3 != 0));
		$display("access test done");
		for (int i = 0; i < 2; i++)
			hold(1'(i));
		$display("hold test done");
		results();
	end
endmodule
